// file: common/pin_mux_pkg.sv
package pin_mux_pkg;
    localparam int NUM_PINS = 21;
    localparam int PIN_IDX_W = 5;
    localparam int BANK_W = 8;
    localparam int RD_W = 16;
    localparam int ADDR_W = 7;
    localparam logic [7:0] BUS_CONFIG_CMD_CODE = 8'hC9;

    // --------
    // function codes and routing kinds
    // --------
    localparam logic [2:0] FN_PRIMARY = 3'h0;
    localparam logic [2:0] FN_BANK_ZERO = 3'h1;
    localparam logic [2:0] FN_BANK_ONE = 3'h2;
    localparam logic [2:0] FN_SYNC = 3'h3;
    localparam logic [2:0] FN_ALT4 = 3'h4;
    localparam logic [2:0] FN_ALT5 = 3'h5;
    localparam logic [2:0] FN_ALT6 = 3'h6;

    typedef enum logic [3:0] {
        K_NONE = 4'h0, K_PRIM = 4'h1, K_G0 = 4'h2, K_G1 = 4'h3, K_SYNC = 4'h4,
        K_URX = 4'h5, K_UTX = 4'h6, K_SDA = 4'h7, K_SCL = 4'h8
    } route_kind_t;

    typedef struct packed {
        route_kind_t kind;
        logic [2:0] bit_sel;
    } route_t;

    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_UP = 2'h1;
    localparam logic [1:0] PULL_DOWN = 2'h2;

    typedef struct packed {
        logic [2:0] func;
        logic dir_out;
        logic open_drain;
        logic [1:0] pull;
        logic lock;
    } pin_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] base_addr;
        logic [3:0] offset_b;
        logic [3:0] offset_a;
        logic strap_en;
    } bus_config_t;

    // --------
    // pin table, index order is package pin order (index 0 lowest)
    // --------
    localparam int P_FAULT_A = 0;
    localparam int P_FAULT_B = 1;
    localparam int P_MON = 2;
    localparam int P_PWM5 = 9;
    localparam int P_PWM6 = 10;
    localparam int P_ALERT = 15;
    localparam int P_BUS_EN = 16;
    localparam int P_BUS_PG = 17;
    localparam int P_SYNC = 18;
    localparam logic [2:0] ALERT_ALT_BIT = 3'h7;
    localparam logic [2:0] BANK_BIT [NUM_PINS] = '{
        3'h2, 3'h2, 3'h3, 3'h6, 3'h7, 3'h5, 3'h7, 3'h1, 3'h2, 3'h3, 3'h4,
        3'h4, 3'h5, 3'h5, 3'h6, 3'h6, 3'h0, 3'h1, 3'h7, 3'h0, 3'h1};

    // strap resistance readings are in units of 10 ohm
    localparam logic [RD_W-1:0] NOM16 [16] = '{
        16'h004E, 16'h006E, 16'h0096, 16'h00CA, 16'h010E, 16'h0160, 16'h01D6,
        16'h025F, 16'h0320, 16'h03FC, 16'h0528, 16'h06B8, 16'h08C7, 16'h0B68,
        16'h0F3C, 16'h15E0};
    localparam logic [RD_W-1:0] NOM8 [8] = '{
        16'h0078, 16'h00B4, 16'h010E, 16'h0186, 16'h02A8, 16'h03E8, 16'h0708,
        16'h125C};

    function automatic route_t route_of(input int pin, input logic [2:0] fn);
        route_t r;
        r.bit_sel = BANK_BIT[pin];
        unique case (fn)
            FN_PRIMARY: r.kind = (pin == P_SYNC) ? K_NONE : K_PRIM;
            FN_BANK_ZERO: r.kind = K_G0;
            FN_BANK_ONE: r.kind = K_G1;
            FN_SYNC: r.kind = K_SYNC;
            default: r.kind = K_NONE;
        endcase
        if (fn == FN_ALT6 && pin == P_FAULT_A) r.kind = K_URX;
        if (fn == FN_ALT6 && pin == P_FAULT_B) r.kind = K_UTX;
        if (fn == FN_ALT5 && (pin == P_FAULT_A || pin == P_BUS_EN)) r.kind = K_SDA;
        if (fn == FN_ALT5 && (pin == P_FAULT_B || pin == P_BUS_PG)) r.kind = K_SCL;
        if (fn == FN_ALT4 && (pin == P_PWM5 || pin == P_BUS_EN)) r.kind = K_URX;
        if (fn == FN_ALT4 && (pin == P_PWM6 || pin == P_BUS_PG)) r.kind = K_UTX;
        if (pin == P_ALERT && (fn == FN_ALT4 || fn == FN_ALT5)) begin
            r.kind = (fn == FN_ALT4) ? K_G0 : K_G1;
            r.bit_sel = ALERT_ALT_BIT;
        end
        return r;
    endfunction
endpackage

// file: design/strap_decoder.sv
`timescale 1ns/1ps
module strap_decoder (
    input wire logic [pin_mux_pkg::RD_W-1:0] reading,
    input wire logic width_sel,
    output logic [3:0] level
);
    // band edges sit midway between neighbouring nominal resistances, so a
    // 1% part plus measurement error still lands in its own band
    logic [4:0] cnt16;
    logic [4:0] cnt8;
    logic [pin_mux_pkg::RD_W:0] edge_sum;

    always_comb begin
        cnt16 = 5'h00;
        cnt8 = 5'h00;
        edge_sum = '0;
        for (int i = 0; i < 15; i++) begin
            edge_sum = {1'b0, pin_mux_pkg::NOM16[i]} + {1'b0, pin_mux_pkg::NOM16[i+1]};
            if ({1'b0, reading} <= (edge_sum >> 1)) cnt16 = cnt16 + 5'h01;
        end
        for (int i = 0; i < 7; i++) begin
            edge_sum = {1'b0, pin_mux_pkg::NOM8[i]} + {1'b0, pin_mux_pkg::NOM8[i+1]};
            if ({1'b0, reading} <= (edge_sum >> 1)) cnt8 = cnt8 + 5'h01;
        end
    end

    assign level = width_sel ? cnt8[3:0] : cnt16[3:0];
endmodule

// file: design/pin_mux_strap.sv
`timescale 1ns/1ps
module pin_mux_strap #(
    parameter bit TWO_STRAP_PINS = 1'b1
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic otp_rec_valid,
    input wire logic [7:0] otp_rec_code,
    input wire pin_mux_pkg::bus_config_t otp_rec_data,
    input wire logic otp_load_done,
    input wire logic strap_decode_width_select,
    input wire logic mon_as_strap,
    input wire logic strap_meas_valid,
    input wire logic [pin_mux_pkg::RD_W-1:0] addr_strap_pin_a,
    input wire logic [pin_mux_pkg::RD_W-1:0] addr_strap_pin_b,
    input wire logic [pin_mux_pkg::RD_W-1:0] mon_reading,
    output logic strap_meas_req,
    output logic [pin_mux_pkg::ADDR_W-1:0] slave_addr,
    output logic slave_addr_valid,
    input wire logic pin_cfg_wr,
    input wire logic [pin_mux_pkg::PIN_IDX_W-1:0] pin_cfg_sel,
    input wire pin_mux_pkg::pin_cfg_t pin_cfg_data,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] prim_out,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] prim_oe,
    input wire logic [pin_mux_pkg::BANK_W-1:0] io_bank_zero_out,
    input wire logic [pin_mux_pkg::BANK_W-1:0] io_bank_one_out,
    input wire logic sync_out,
    input wire logic sync_out_en,
    input wire logic serial_tx,
    input wire logic aux_i2c_data_low,
    input wire logic aux_i2c_clock_low,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_in,
    output logic [pin_mux_pkg::NUM_PINS-1:0] pad_out,
    output logic [pin_mux_pkg::NUM_PINS-1:0] pad_oe,
    output logic [pin_mux_pkg::NUM_PINS-1:0] pad_pull_up,
    output logic [pin_mux_pkg::NUM_PINS-1:0] pad_pull_down,
    output logic [pin_mux_pkg::NUM_PINS-1:0] pad_level,
    output logic [pin_mux_pkg::BANK_W-1:0] io_bank_zero_in,
    output logic [pin_mux_pkg::BANK_W-1:0] io_bank_one_in,
    output logic sync_in,
    output logic serial_rx,
    output logic aux_i2c_data_in,
    output logic aux_i2c_clock_in,
    output logic current_monitor_pin_analog
);
    localparam int N = pin_mux_pkg::NUM_PINS;

    // --------
    // initialisation sequence
    // --------
    typedef enum logic [2:0] {
        ST_LOAD = 3'b001, ST_MEASURE = 3'b010, ST_READY = 3'b100
    } init_state_t;

    init_state_t state_r, state_nxt;
    pin_mux_pkg::bus_config_t cfg_r;
    logic width_r;
    logic mon_strap_r;
    logic [3:0] lvl_a_r, lvl_b_r;
    logic [3:0] lvl_a, lvl_b;
    logic [pin_mux_pkg::RD_W-1:0] reading_b;
    logic [7:0] offset;
    logic [7:0] addr_sum;
    logic cfg_hit;
    logic use_b;

    // the bus config is only ever taken from the stored image during load,
    // so a new setting needs storing and a power cycle before it shows
    assign cfg_hit = (state_r == ST_LOAD) && otp_rec_valid &&
                     (otp_rec_code == pin_mux_pkg::BUS_CONFIG_CMD_CODE);
    assign use_b = TWO_STRAP_PINS || mon_strap_r;
    assign reading_b = TWO_STRAP_PINS ? addr_strap_pin_b : mon_reading;

    strap_decoder u_dec_a (
        .reading(addr_strap_pin_a),
        .width_sel(width_r),
        .level(lvl_a)
    );

    strap_decoder u_dec_b (
        .reading(reading_b),
        .width_sel(width_r),
        .level(lvl_b)
    );

    // second pin forms the upper digit of the offset
    assign offset = !cfg_r.strap_en ? {cfg_r.offset_b, cfg_r.offset_a} :
                    !use_b ? {4'h0, lvl_a_r} :
                    width_r ? {2'h0, lvl_b_r[2:0], lvl_a_r[2:0]} :
                    {lvl_b_r, lvl_a_r};
    assign addr_sum = {1'b0, cfg_r.base_addr} + offset;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_LOAD: if (otp_load_done) begin
                state_nxt = cfg_r.strap_en ? ST_MEASURE : ST_READY;
            end
            ST_MEASURE: if (strap_meas_valid) begin
                state_nxt = ST_READY;
            end
            ST_READY: state_nxt = ST_READY;
            default: state_nxt = ST_LOAD;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_r <= ST_LOAD;
            cfg_r <= '0;
            width_r <= 1'b0;
            mon_strap_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (cfg_hit) cfg_r <= otp_rec_data;
            if (state_r == ST_LOAD) begin
                width_r <= strap_decode_width_select;
                mon_strap_r <= mon_as_strap;
            end
        end
    end

    // straps are captured once; later pin changes are ignored until reset
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            lvl_a_r <= 4'h0;
            lvl_b_r <= 4'h0;
            strap_meas_req <= 1'b0;
            slave_addr <= '0;
            slave_addr_valid <= 1'b0;
        end else begin
            strap_meas_req <= (state_nxt == ST_MEASURE);
            if (state_r == ST_MEASURE && strap_meas_valid) begin
                lvl_a_r <= lvl_a;
                lvl_b_r <= lvl_b;
            end
            if (state_r == ST_READY && !slave_addr_valid) begin
                slave_addr <= addr_sum[pin_mux_pkg::ADDR_W-1:0];
                slave_addr_valid <= 1'b1;
            end
        end
    end

    // --------
    // per-pin configuration
    // --------
    pin_mux_pkg::pin_cfg_t pin_cfg_r [N];
    logic [N-1:0] cfg_we;

    always_ff @(posedge mclk) begin
        for (int i = 0; i < N; i++) begin
            if (!reset_n) begin
                pin_cfg_r[i] <= '0;
            end else if (cfg_we[i]) begin
                pin_cfg_r[i] <= pin_cfg_data;
            end
        end
    end

    // --------
    // pad input synchronisers
    // --------
    logic [N-1:0] sync1_r, sync2_r, sync3_r, level_r;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            level_r <= '0;
        end else begin
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            // a change counts only once the last two stages agree
            level_r <= (sync2_r & sync3_r) | (level_r & (sync2_r | sync3_r));
        end
    end

    // --------
    // routing
    // --------
    pin_mux_pkg::route_t rt [N];
    logic [N-1:0] out_nxt, oe_nxt, pu_nxt, pd_nxt;
    logic [pin_mux_pkg::BANK_W-1:0] g0_nxt, g1_nxt;
    logic sync_nxt, rx_nxt, sda_nxt, scl_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_pin
            assign rt[gi] = pin_mux_pkg::route_of(gi, pin_cfg_r[gi].func);
            assign cfg_we[gi] = pin_cfg_wr && (int'(pin_cfg_sel) == gi) &&
                                !pin_cfg_r[gi].lock;
        end
    endgenerate

    always_comb begin
        out_nxt = '0;
        oe_nxt = '0;
        pu_nxt = '0;
        pd_nxt = '0;
        for (int i = 0; i < N; i++) begin
            unique case (rt[i].kind)
                pin_mux_pkg::K_PRIM: begin
                    out_nxt[i] = prim_out[i];
                    oe_nxt[i] = prim_oe[i];
                end
                pin_mux_pkg::K_G0, pin_mux_pkg::K_G1: begin
                    out_nxt[i] = (rt[i].kind == pin_mux_pkg::K_G0) ?
                                 io_bank_zero_out[rt[i].bit_sel] :
                                 io_bank_one_out[rt[i].bit_sel];
                    if (pin_cfg_r[i].dir_out) begin
                        // open drain only ever pulls low
                        oe_nxt[i] = !pin_cfg_r[i].open_drain || !out_nxt[i];
                        if (pin_cfg_r[i].open_drain) out_nxt[i] = 1'b0;
                    end else begin
                        pu_nxt[i] = (pin_cfg_r[i].pull == pin_mux_pkg::PULL_UP);
                        pd_nxt[i] = (pin_cfg_r[i].pull == pin_mux_pkg::PULL_DOWN);
                    end
                end
                pin_mux_pkg::K_SYNC: begin
                    out_nxt[i] = sync_out;
                    oe_nxt[i] = sync_out_en;
                end
                pin_mux_pkg::K_UTX: begin
                    out_nxt[i] = serial_tx;
                    oe_nxt[i] = 1'b1;
                end
                pin_mux_pkg::K_SDA: oe_nxt[i] = aux_i2c_data_low;
                pin_mux_pkg::K_SCL: oe_nxt[i] = aux_i2c_clock_low;
                default: oe_nxt[i] = 1'b0;
            endcase
        end
    end

    // walk from the highest pin down so the lowest selecting pin wins
    always_comb begin
        g0_nxt = '0;
        g1_nxt = '0;
        sync_nxt = 1'b0;
        rx_nxt = 1'b1;
        sda_nxt = 1'b1;
        scl_nxt = 1'b1;
        for (int i = N - 1; i >= 0; i--) begin
            unique case (rt[i].kind)
                pin_mux_pkg::K_G0: g0_nxt[rt[i].bit_sel] = level_r[i];
                pin_mux_pkg::K_G1: g1_nxt[rt[i].bit_sel] = level_r[i];
                pin_mux_pkg::K_SYNC: sync_nxt = level_r[i];
                pin_mux_pkg::K_URX: rx_nxt = level_r[i];
                pin_mux_pkg::K_SDA: sda_nxt = level_r[i];
                pin_mux_pkg::K_SCL: scl_nxt = level_r[i];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pad_out <= '0;
            pad_oe <= '0;
            pad_pull_up <= '0;
            pad_pull_down <= '0;
            pad_level <= '0;
            io_bank_zero_in <= '0;
            io_bank_one_in <= '0;
            sync_in <= 1'b0;
            serial_rx <= 1'b1;
            aux_i2c_data_in <= 1'b1;
            aux_i2c_clock_in <= 1'b1;
            current_monitor_pin_analog <= 1'b0;
        end else begin
            pad_out <= out_nxt;
            pad_oe <= oe_nxt;
            pad_pull_up <= pu_nxt;
            pad_pull_down <= pd_nxt;
            pad_level <= level_r;
            io_bank_zero_in <= g0_nxt;
            io_bank_one_in <= g1_nxt;
            sync_in <= sync_nxt;
            serial_rx <= rx_nxt;
            aux_i2c_data_in <= sda_nxt;
            aux_i2c_clock_in <= scl_nxt;
            // analog monitor path only when not borrowed as a strap input
            current_monitor_pin_analog <= (rt[pin_mux_pkg::P_MON].kind ==
                pin_mux_pkg::K_PRIM) && !(mon_strap_r && !TWO_STRAP_PINS);
        end
    end
endmodule

// file: dv/pin_mux_checker.sv
`timescale 1ns/1ps
module pin_mux_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic strap_meas_valid,
    input wire logic strap_meas_req,
    input wire logic [pin_mux_pkg::ADDR_W-1:0] slave_addr,
    input wire logic slave_addr_valid,
    input wire logic pin_cfg_wr,
    input wire logic [pin_mux_pkg::PIN_IDX_W-1:0] pin_cfg_sel,
    input wire pin_mux_pkg::pin_cfg_t pin_cfg_data,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] prim_out,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] prim_oe,
    input wire logic [pin_mux_pkg::BANK_W-1:0] io_bank_zero_out,
    input wire logic [pin_mux_pkg::BANK_W-1:0] io_bank_one_out,
    input wire logic serial_tx,
    input wire logic aux_i2c_data_low,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_out,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_oe,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_pull_up,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_pull_down
);
    pin_mux_pkg::pin_cfg_t cfg_m [pin_mux_pkg::NUM_PINS];
    pin_mux_pkg::pin_cfg_t c0, c3, c10, c16;
    logic [1:0] quiet_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // --------
    // mirror of accepted pin settings
    // --------
    // a locked entry ignores writes, so pads must keep the old route
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) cfg_m[i] <= '0;
        end else if (pin_cfg_wr && pin_cfg_sel < 5'(pin_mux_pkg::NUM_PINS)
                && !cfg_m[pin_cfg_sel].lock) begin
            cfg_m[pin_cfg_sel] <= pin_cfg_data;
        end
    end
    // pads are only judged once two edges passed without a write
    always_ff @(posedge mclk) begin
        if (!reset_n || pin_cfg_wr) quiet_r <= 2'h0;
        else if (quiet_r != 2'h3) quiet_r <= quiet_r + 2'h1;
    end
    assign c0 = cfg_m[0];
    assign c3 = cfg_m[3];
    assign c10 = cfg_m[10];
    assign c16 = cfg_m[16];
    // --------
    // properties
    // --------
    valid_hold_a: assert property (slave_addr_valid |=> slave_addr_valid)
        else $error("address valid dropped");
    addr_frozen_a: assert property (slave_addr_valid |=> $stable(slave_addr))
        else $error("address changed after init");
    meas_done_a: assert property (strap_meas_req && strap_meas_valid
        |=> !strap_meas_req ##1 slave_addr_valid) else $error("strap result not taken");
    req_blocks_a: assert property (strap_meas_req |-> !slave_addr_valid)
        else $error("address valid while measuring");
    prim_route_a: assert property (quiet_r[1] && c3.func == pin_mux_pkg::FN_PRIMARY
        |-> pad_out[3] == $past(prim_out[3]) && pad_oe[3] == $past(prim_oe[3]))
        else $error("primary route wrong");
    bank_route_a: assert property (quiet_r[1] && c3.func == pin_mux_pkg::FN_BANK_ONE
        && c3.dir_out && !c3.open_drain |-> pad_oe[3] && pad_out[3] == $past(io_bank_one_out[6]))
        else $error("bank one route wrong");
    od_drive_a: assert property (quiet_r[1] && c0.func == pin_mux_pkg::FN_BANK_ZERO
        && c0.dir_out && c0.open_drain |-> !pad_out[0] && pad_oe[0] == !$past(io_bank_zero_out[2]))
        else $error("open drain drive wrong");
    pull_sel_a: assert property (quiet_r[1] && c0.func == pin_mux_pkg::FN_BANK_ZERO
        && !c0.dir_out |-> pad_pull_up[0] == (c0.pull == pin_mux_pkg::PULL_UP)
        && pad_pull_down[0] == (c0.pull == pin_mux_pkg::PULL_DOWN)) else $error("pull wrong");
    tx_route_a: assert property (quiet_r[1] && c10.func == pin_mux_pkg::FN_ALT4
        |-> pad_oe[10] && pad_out[10] == $past(serial_tx)) else $error("serial tx route wrong");
    aux_drive_a: assert property (quiet_r[1] && c16.func == pin_mux_pkg::FN_ALT5
        |-> !pad_out[16] && pad_oe[16] == $past(aux_i2c_data_low)) else $error("aux drive wrong");
    cover property (strap_meas_req && strap_meas_valid);
    cover property ($rose(slave_addr_valid));
    cover property (pin_cfg_wr && pin_cfg_sel == 5'h0A && c10.lock);
endmodule
bind pin_mux_strap pin_mux_checker chk_i (.mclk, .reset_n, .strap_meas_valid, .strap_meas_req,
    .slave_addr, .slave_addr_valid, .pin_cfg_wr, .pin_cfg_sel, .pin_cfg_data, .prim_out,
    .prim_oe, .io_bank_zero_out, .io_bank_one_out, .serial_tx, .aux_i2c_data_low, .pad_out,
    .pad_oe, .pad_pull_up, .pad_pull_down);

// file: dv/board_model.sv
`timescale 1ns/1ps
module board_model (
    input wire logic mclk,
    input wire logic strap_meas_req,
    input wire logic [3:0] lag,
    input wire logic [15:0] res_a,
    input wire logic [15:0] res_b,
    input wire logic [20:0] pad_out,
    input wire logic [20:0] pad_oe,
    input wire logic [20:0] pad_pull_up,
    input wire logic [20:0] pad_pull_down,
    input wire logic [20:0] board_oe,
    input wire logic [20:0] board_val,
    output logic strap_meas_valid,
    output logic [15:0] addr_strap_pin_a,
    output logic [15:0] addr_strap_pin_b,
    output logic [15:0] mon_reading,
    output logic [20:0] pad_in
);
    logic [3:0] wait_r = 4'h0;
    logic sent_r = 1'b0;
    logic valid_r = 1'b0;
    logic [15:0] junk_r = 16'h0000;
    // --------
    // strap meter: one answer per request, after lag cycles
    // --------
    always @(posedge mclk) begin
        junk_r <= junk_r + 16'h3B5D;
        valid_r <= 1'b0;
        if (!strap_meas_req) begin
            wait_r <= 4'h0;
            sent_r <= 1'b0;
        end else if (!sent_r && wait_r == lag) begin
            valid_r <= 1'b1;
            sent_r <= 1'b1;
        end else if (!sent_r) begin
            wait_r <= wait_r + 4'h1;
        end
    end
    assign strap_meas_valid = valid_r;
    // readings wander outside the valid pulse so a late sample shows up
    assign addr_strap_pin_a = valid_r ? res_a : junk_r;
    assign addr_strap_pin_b = valid_r ? res_b : ~junk_r;
    assign mon_reading = junk_r ^ 16'h5A5A;
    // wire level: device drive, then board drive, then pull, else floating
    always_comb begin
        for (int i = 0; i < 21; i++) begin
            if (pad_oe[i]) pad_in[i] = pad_out[i];
            else if (board_oe[i]) pad_in[i] = board_val[i];
            else if (pad_pull_up[i] || pad_pull_down[i]) pad_in[i] = pad_pull_up[i];
            else pad_in[i] = junk_r[i % 16];
        end
    end
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic otp_rec_valid = 1'b0;
    logic [7:0] otp_rec_code = 8'h00;
    pin_mux_pkg::bus_config_t otp_rec_data = '0;
    logic otp_load_done = 1'b0;
    logic strap_decode_width_select = 1'b0;
    logic mon_as_strap = 1'b0;
    logic strap_meas_valid, strap_meas_req, slave_addr_valid, sync_in, serial_rx;
    logic [15:0] addr_strap_pin_a, addr_strap_pin_b, mon_reading;
    logic [6:0] slave_addr;
    logic pin_cfg_wr = 1'b0;
    logic [4:0] pin_cfg_sel = 5'h00;
    pin_mux_pkg::pin_cfg_t pin_cfg_data = '0;
    logic [20:0] prim_out = 21'h000000, prim_oe = 21'h000000;
    logic [7:0] io_bank_zero_out = 8'h00, io_bank_one_out = 8'h00;
    logic sync_out = 1'b0, sync_out_en = 1'b0, serial_tx = 1'b0;
    logic aux_i2c_data_low = 1'b0, aux_i2c_clock_low = 1'b0;
    logic [20:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, pad_level;
    logic [7:0] io_bank_zero_in, io_bank_one_in;
    logic aux_i2c_data_in, aux_i2c_clock_in, current_monitor_pin_analog;
    logic [3:0] lag = 4'h0;
    logic [15:0] res_a = 16'hFFFF, res_b = 16'hFFFF;
    logic [20:0] board_oe = 21'h000000, board_val = 21'h000000;
    int num_errors = 0, n_checks = 0, cyc = 0;
    always #2.5 mclk = ~mclk;
    pin_mux_strap dut (.mclk, .reset_n, .otp_rec_valid, .otp_rec_code, .otp_rec_data,
        .otp_load_done, .strap_decode_width_select, .mon_as_strap, .strap_meas_valid,
        .addr_strap_pin_a, .addr_strap_pin_b, .mon_reading, .strap_meas_req, .slave_addr,
        .slave_addr_valid, .pin_cfg_wr, .pin_cfg_sel, .pin_cfg_data, .prim_out, .prim_oe,
        .io_bank_zero_out, .io_bank_one_out, .sync_out, .sync_out_en, .serial_tx,
        .aux_i2c_data_low, .aux_i2c_clock_low, .pad_in, .pad_out, .pad_oe, .pad_pull_up,
        .pad_pull_down, .pad_level, .io_bank_zero_in, .io_bank_one_in, .sync_in, .serial_rx,
        .aux_i2c_data_in, .aux_i2c_clock_in, .current_monitor_pin_analog);
    board_model board (.mclk, .strap_meas_req, .lag, .res_a, .res_b, .pad_out, .pad_oe,
        .pad_pull_up, .pad_pull_down, .board_oe, .board_val, .strap_meas_valid,
        .addr_strap_pin_a, .addr_strap_pin_b, .mon_reading, .pad_in);
    // --------
    // shared tasks
    // --------
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            give_verdict();
        end
    end
    // power cycle and image replay: a foreign record first, a late one after
    task automatic boot(input pin_mux_pkg::bus_config_t c, input logic wsel);
        @(posedge mclk);
        reset_n <= 1'b0;
        strap_decode_width_select <= wsel;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        otp_rec_valid <= 1'b1;
        otp_rec_code <= 8'h3C;
        otp_rec_data <= ~c;
        @(posedge mclk);
        otp_rec_code <= pin_mux_pkg::BUS_CONFIG_CMD_CODE;
        otp_rec_data <= c;
        @(posedge mclk);
        otp_rec_valid <= 1'b0;
        otp_load_done <= 1'b1;
        @(posedge mclk);
        otp_load_done <= 1'b0;
        for (int i = 0; i < 30 && slave_addr_valid !== 1'b1; i++) step(1);
        @(posedge mclk);
        otp_rec_valid <= 1'b1;
        otp_rec_data <= ~c;
        @(posedge mclk);
        otp_rec_valid <= 1'b0;
        step(3);
        chk("addr_valid", 16'h0001, 16'(slave_addr_valid));
    endtask
    task automatic wcfg(input int pin, input pin_mux_pkg::pin_cfg_t c);
        @(posedge mclk);
        pin_cfg_wr <= 1'b1;
        pin_cfg_sel <= 5'(pin);
        pin_cfg_data <= c;
        @(posedge mclk);
        pin_cfg_wr <= 1'b0;
        step(3);
    endtask
    // --------
    // scenarios
    // --------
    task automatic t_addr();
        boot('{7'h10, 4'h2, 4'h3, 1'b0}, 1'b0);
        chk("addr_cfg", 16'h0033, 16'(slave_addr));
        lag <= 4'h0;
        res_a <= 16'h004E;
        res_b <= 16'h0F3C;
        boot('{7'h20, 4'h5, 4'h5, 1'b1}, 1'b0);
        chk("addr_s16", 16'h003F, 16'(slave_addr));
        step(10);
        chk("addr_s16_held", 16'h003F, 16'(slave_addr));
        lag <= 4'h6;
        res_a <= 16'h0078;
        res_b <= 16'h00B4;
        boot('{7'h50, 4'h0, 4'h0, 1'b1}, 1'b1);
        chk("addr_s8_wrap", 16'h0007, 16'(slave_addr));
        $display("test addr done");
    endtask
    task automatic t_pins();
        logic [2:0] fn [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
        logic [1:0] ex [4] = '{2'h2, 2'h3, 2'h2, 2'h0};
        @(posedge mclk);
        prim_oe <= 21'h000008;
        io_bank_zero_out <= 8'h40;
        serial_tx <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wcfg(3, '{fn[k], 1'b1, 1'b0, 2'h0, 1'b0});
            chk("pad3", 16'(ex[k]), 16'({pad_oe[3], pad_out[3]}));
        end
        wcfg(0, '{3'h1, 1'b1, 1'b1, 2'h0, 1'b0});
        chk("pad0_od_low", 16'h0002, 16'({pad_oe[0], pad_out[0]}));
        @(posedge mclk);
        io_bank_zero_out <= 8'h44;
        step(2);
        chk("pad0_od_rel", 16'h0000, 16'({pad_oe[0], pad_out[0]}));
        wcfg(0, '{3'h1, 1'b0, 1'b0, pin_mux_pkg::PULL_UP, 1'b0});
        step(6);
        chk("pull_up", 16'h0005, 16'({pad_pull_up[0], pad_pull_down[0],
            io_bank_zero_in[2]}));
        wcfg(0, '{3'h1, 1'b0, 1'b0, pin_mux_pkg::PULL_DOWN, 1'b0});
        step(6);
        chk("pull_dn", 16'h0002, 16'({pad_pull_up[0], pad_pull_down[0],
            io_bank_zero_in[2]}));
        wcfg(10, '{3'h4, 1'b1, 1'b0, 2'h0, 1'b1});
        chk("tx_pad", 16'h0003, 16'({pad_oe[10], pad_out[10]}));
        wcfg(10, '{3'h0, 1'b1, 1'b0, 2'h0, 1'b0});
        @(posedge mclk);
        serial_tx <= 1'b0;
        step(2);
        chk("tx_locked", 16'h0002, 16'({pad_oe[10], pad_out[10]}));
        $display("test pins done");
    endtask
    task automatic t_inputs();
        wcfg(1, '{3'h3, 1'b0, 1'b0, 2'h0, 1'b0});
        wcfg(3, '{3'h3, 1'b0, 1'b0, 2'h0, 1'b0});
        wcfg(9, '{3'h4, 1'b0, 1'b0, 2'h0, 1'b0});
        wcfg(16, '{3'h5, 1'b0, 1'b0, 2'h0, 1'b0});
        @(posedge mclk);
        aux_i2c_data_low <= 1'b1;
        board_oe <= 21'h00020A;
        board_val <= 21'h000002;
        step(8);
        chk("in_a", 16'h0054, 16'({current_monitor_pin_analog,
            pad_level[16], sync_in, serial_rx, pad_oe[16], pad_out[16], aux_i2c_data_in}));
        @(posedge mclk);
        aux_i2c_data_low <= 1'b0;
        board_oe <= 21'h01020A;
        board_val <= 21'h010208;
        step(8);
        chk("in_b", 16'h0069, 16'({current_monitor_pin_analog,
            pad_level[16], sync_in, serial_rx, pad_oe[16], pad_out[16], aux_i2c_data_in}));
        $display("test inputs done");
    endtask
    initial begin
        t_addr();
        t_pins();
        t_inputs();
        give_verdict();
    end
endmodule
